// [logic/rsp_pkg.sv]
// Overview of operation
// - Host-ready output is undefined during reset and for 100 ms after.
// - During reset the shared pin is an input sampled as environment strap.
// - An undriven shared pin reads as strap value 1 through the pull-up.
// - After reset the shared pin drives the active-low expansion select.
// - Power-down lowers the clock rate and switches off some modules.
// - Power-down keeps stored messages and keeps date and time running.
// - Power-down drives all four message-memory selects to 1.
// - Power-down keeps issuing refresh cycles to dynamic message memories.
// - Port-B lines, bits 3 to 6, select the active message-memory device.
package rsp_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned READY_HOLD_MS = 100;
	localparam int unsigned READY_HOLD_CYC = CLK_HZ / 1000 * READY_HOLD_MS;
	localparam int unsigned NUM_MSG_MEM = 4;
	localparam int unsigned SLOW_DIV = 16;
	localparam int unsigned REFRESH_CYC = 1560;
	localparam int unsigned TICK_CYC = 100000;
	localparam logic [3:0] SEL_ALL_OFF = 4'hf;
	localparam logic STRAP_RESET = 1'h1;

	typedef struct packed {
		logic powerDown;
		logic selValid;
		logic [1:0] selIndex;
		logic extMemAccess;
	} rsp_ctrl_t;

	typedef struct packed {
		logic [3:0] portBDeviceSelectLines;
		logic expansionMemSelectN;
		logic expansionMemSelectOe;
		logic refreshStrobe;
		logic clockSlowEnable;
		logic modulesOn;
		logic timeTick;
	} rsp_out_t;
endpackage

// [logic/rsp_reset_strap_powerdown_ctrl.sv]
`timescale 1ns/1ns
module rsp_reset_strap_powerdown_ctrl #(
	parameter int unsigned READY_HOLD_CYC = rsp_pkg::READY_HOLD_CYC,
	parameter int unsigned REFRESH_CYC = rsp_pkg::REFRESH_CYC,
	parameter int unsigned TICK_CYC = rsp_pkg::TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic resetInN,
	input wire logic testModeInput,
	input wire logic strapPinIn,
	input wire rsp_pkg::rsp_ctrl_t ctrlIn,
	input wire logic coreReady,
	output rsp_pkg::rsp_out_t outBus,
	output logic hostLinkReady,
	output logic hostLinkReadyValid,
	output logic environmentStrap,
	output logic inReset,
	output logic [31:0] timeOfDay
);
	// Pin inputs pass three flops; a reset or strap change counts once stages 2 and 3 agree.
	logic [2:0] rstSync_ff;
	logic [2:0] strapSync_ff;
	logic [2:0] tstSync_ff;
	logic rstFilt_ff;
	logic nxt_rstFilt;
	logic strapFilt_ff;
	logic nxt_strapFilt;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rstSync_ff <= 3'h0;
			strapSync_ff <= 3'h7;
			tstSync_ff <= 3'h7;
			rstFilt_ff <= 1'h1;
			strapFilt_ff <= rsp_pkg::STRAP_RESET;
		end else begin
			rstSync_ff <= {rstSync_ff[1:0], resetInN};
			strapSync_ff <= {strapSync_ff[1:0], strapPinIn};
			tstSync_ff <= {tstSync_ff[1:0], testModeInput};
			rstFilt_ff <= nxt_rstFilt;
			strapFilt_ff <= nxt_strapFilt;
		end
	end

	always_comb begin
		nxt_rstFilt = rstFilt_ff;
		nxt_strapFilt = strapFilt_ff;
		if (rstSync_ff[1] == rstSync_ff[2]) begin
			nxt_rstFilt = ~rstSync_ff[2];
		end
		if (strapSync_ff[1] == strapSync_ff[2]) begin
			nxt_strapFilt = strapSync_ff[2];
		end
	end

	typedef enum {ST_RESET, ST_SETTLE, ST_RUN, ST_POWERDOWN} rsp_state_t;
	rsp_state_t state_ff;
	rsp_state_t nxt_state;
	logic [31:0] holdCnt_ff;
	logic [31:0] nxt_holdCnt;
	logic strap_ff;
	logic nxt_strap;
	logic [31:0] refCnt_ff;
	logic [31:0] nxt_refCnt;
	logic [31:0] tickCnt_ff;
	logic [31:0] nxt_tickCnt;
	logic [31:0] tod_ff;
	logic [31:0] nxt_tod;
	logic [3:0] slowCnt_ff;
	logic [3:0] nxt_slowCnt;
	rsp_pkg::rsp_out_t out_ff;
	rsp_pkg::rsp_out_t nxt_out;
	logic ready_ff;
	logic nxt_ready;
	logic readyValid_ff;
	logic nxt_readyValid;

	function automatic logic [3:0] decodeSel(input logic v, input logic [1:0] i);
		decodeSel = rsp_pkg::SEL_ALL_OFF;
		if (v) begin
			decodeSel[i] = 1'h0;
		end
	endfunction

	always_comb begin
		nxt_state = state_ff;
		nxt_holdCnt = holdCnt_ff;
		nxt_strap = strap_ff;
		nxt_refCnt = refCnt_ff;
		nxt_tickCnt = tickCnt_ff;
		nxt_tod = tod_ff;
		nxt_slowCnt = slowCnt_ff + 4'h1;
		nxt_out = '0;
		nxt_ready = 1'h0;
		nxt_readyValid = 1'h0;
		// Timekeeping runs in every state after reset, power-down included.
		if (tickCnt_ff >= TICK_CYC - 1) begin
			nxt_tickCnt = 32'h0;
			nxt_tod = tod_ff + 32'h1;
			nxt_out.timeTick = 1'h1;
		end else begin
			nxt_tickCnt = tickCnt_ff + 32'h1;
		end
		// Refresh keeps dynamic message memory alive in run and power-down.
		if (refCnt_ff >= REFRESH_CYC - 1) begin
			nxt_refCnt = 32'h0;
			nxt_out.refreshStrobe = 1'h1;
		end else begin
			nxt_refCnt = refCnt_ff + 32'h1;
		end
		nxt_out.portBDeviceSelectLines = rsp_pkg::SEL_ALL_OFF;
		nxt_out.expansionMemSelectN = 1'h1;
		case (state_ff)
			ST_RESET: begin
				nxt_strap = strapFilt_ff;
				nxt_holdCnt = 32'h0;
				nxt_refCnt = 32'h0;
				nxt_tickCnt = 32'h0;
				nxt_out.refreshStrobe = 1'h0;
				nxt_out.timeTick = 1'h0;
				if (!rstFilt_ff) begin
					nxt_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				nxt_out.expansionMemSelectOe = 1'h1;
				nxt_out.modulesOn = 1'h1;
				if (holdCnt_ff >= READY_HOLD_CYC - 1) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_holdCnt = holdCnt_ff + 32'h1;
				end
			end
			ST_RUN: begin
				nxt_out.expansionMemSelectOe = 1'h1;
				nxt_out.expansionMemSelectN = ~ctrlIn.extMemAccess;
				nxt_out.modulesOn = 1'h1;
				nxt_out.portBDeviceSelectLines =
					decodeSel(ctrlIn.selValid, ctrlIn.selIndex);
				nxt_ready = coreReady;
				nxt_readyValid = 1'h1;
				if (ctrlIn.powerDown) begin
					nxt_state = ST_POWERDOWN;
				end
			end
			ST_POWERDOWN: begin
				nxt_out.expansionMemSelectOe = 1'h1;
				nxt_out.clockSlowEnable = (slowCnt_ff == 4'h0);
				nxt_out.modulesOn = 1'h0;
				nxt_out.portBDeviceSelectLines = rsp_pkg::SEL_ALL_OFF;
				nxt_readyValid = 1'h1;
				if (!ctrlIn.powerDown) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RESET;
			end
		endcase
		if (state_ff != ST_POWERDOWN) begin
			nxt_out.clockSlowEnable = 1'h1;
		end
		if (rstFilt_ff) begin
			nxt_state = ST_RESET;
			nxt_out = '0;
			nxt_out.portBDeviceSelectLines = rsp_pkg::SEL_ALL_OFF;
			nxt_out.expansionMemSelectN = 1'h1;
			nxt_ready = 1'h0;
			nxt_readyValid = 1'h0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= ST_RESET;
			holdCnt_ff <= 32'h0;
			strap_ff <= rsp_pkg::STRAP_RESET;
			refCnt_ff <= 32'h0;
			tickCnt_ff <= 32'h0;
			tod_ff <= 32'h0;
			slowCnt_ff <= 4'h0;
			out_ff <= '{portBDeviceSelectLines: 4'hf, expansionMemSelectN: 1'h1,
				default: 1'h0};
			ready_ff <= 1'h0;
			readyValid_ff <= 1'h0;
		end else begin
			state_ff <= nxt_state;
			holdCnt_ff <= nxt_holdCnt;
			strap_ff <= nxt_strap;
			refCnt_ff <= nxt_refCnt;
			tickCnt_ff <= nxt_tickCnt;
			tod_ff <= nxt_tod;
			slowCnt_ff <= nxt_slowCnt;
			out_ff <= nxt_out;
			ready_ff <= nxt_ready;
			readyValid_ff <= nxt_readyValid;
		end
	end

	logic inReset_ff;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			inReset_ff <= 1'h1;
		end else begin
			inReset_ff <= (nxt_state == ST_RESET);
		end
	end

	assign outBus = out_ff;
	assign hostLinkReady = ready_ff;
	assign hostLinkReadyValid = readyValid_ff;
	assign environmentStrap = strap_ff;
	assign inReset = inReset_ff;
	assign timeOfDay = tod_ff;
endmodule

// [bench/rsp_ctrl_monitor.sv]
`timescale 1ns/1ns
module rsp_ctrl_monitor #(
	parameter int unsigned READY_HOLD_CYC = rsp_pkg::READY_HOLD_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire rsp_pkg::rsp_ctrl_t ctrlIn,
	input wire rsp_pkg::rsp_out_t outBus,
	input wire logic hostLinkReadyValid,
	input wire logic environmentStrap,
	input wire logic inReset
);
	int unsigned runCnt;
	logic run;
	assign run = hostLinkReadyValid && !inReset;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Counts every cycle since reset left, saturating once the window is over.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			runCnt <= 0;
		end else if (inReset) begin
			runCnt <= 0;
		end else if (runCnt < READY_HOLD_CYC) begin
			runCnt <= runCnt + 1;
		end
	end
	AST_READY_WIN: assert property (
		hostLinkReadyValid |-> runCnt >= READY_HOLD_CYC - 1)
		else $error("ready valid too early");
	AST_OE_RST: assert property (
		inReset ##1 inReset |-> !outBus.expansionMemSelectOe)
		else $error("pin driven in reset");
	AST_OE_RUN: assert property (
		!inReset ##1 !inReset |-> outBus.expansionMemSelectOe)
		else $error("pin not driven");
	// Power-down outputs appear one cycle after the state has changed.
	AST_PD_MODS: assert property (
		run && ctrlIn.powerDown |-> ##2 !outBus.modulesOn)
		else $error("modules still on");
	AST_PD_SEL: assert property (
		run && ctrlIn.powerDown |-> ##2 outBus.portBDeviceSelectLines == 4'hf)
		else $error("selects not parked");
	AST_PD_REFRESH: assert property (
		run && ctrlIn.powerDown |-> ##[1:10] outBus.refreshStrobe)
		else $error("refresh missing");
	// Only in run: the previous request kept the block out of power-down.
	AST_DEV_SEL: assert property (
		run && ctrlIn.selValid && !ctrlIn.powerDown &&
		!$past(ctrlIn.powerDown) ##1 !inReset |->
		outBus.portBDeviceSelectLines == ~(4'h1 << $past(ctrlIn.selIndex)))
		else $error("wrong device select");
	AST_STRAP_HOLD: assert property (
		!inReset ##1 !inReset |-> $stable(environmentStrap))
		else $error("strap changed");
endmodule

bind rsp_reset_strap_powerdown_ctrl rsp_ctrl_monitor #(
	.READY_HOLD_CYC(READY_HOLD_CYC)
) rsp_ctrl_monitor_i (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.ctrlIn(ctrlIn),
	.outBus(outBus),
	.hostLinkReadyValid(hostLinkReadyValid),
	.environmentStrap(environmentStrap),
	.inReset(inReset)
);

// [bench/rsp_host_model.sv]
`timescale 1ns/1ns
module rsp_host_model (
	input wire logic clk_sys,
	input wire logic pinOe,
	input wire logic pinOut,
	input wire logic strapDrive,
	input wire logic strapVal,
	output logic resetInN,
	output logic testModeInput,
	output logic strapPinIn
);
	initial begin
		resetInN = 1'h0;
		testModeInput = 1'h1;
	end
	// The pull-up wins when nobody drives the shared pin.
	assign strapPinIn = pinOe ? pinOut : strapDrive ? strapVal : 1'h1;
	task automatic hold_reset(input int n);
		@(negedge clk_sys) resetInN = 1'h0;
		repeat (n) @(negedge clk_sys);
		resetInN = 1'h1;
	endtask
endmodule

// [bench/rsp_reset_strap_powerdown_ctrl_tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: mismatch", $time); end end
module rsp_reset_strap_powerdown_ctrl_tb;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic drv = 1'h0;
	logic val = 1'h0;
	rsp_pkg::rsp_ctrl_t ctrl = '0;
	rsp_pkg::rsp_out_t ob;
	logic vld, strap, inRst, rstN, tst, pin, rdy;
	logic core = 1'h1;
	logic [31:0] tod;
	int bad_count = 0;
	int n_compared = 0;
	initial forever #5 clk_sys = ~clk_sys;
	rsp_host_model rsp_host_model_i (.clk_sys(clk_sys),
		.pinOe(ob.expansionMemSelectOe), .pinOut(ob.expansionMemSelectN),
		.strapDrive(drv), .strapVal(val), .resetInN(rstN),
		.testModeInput(tst), .strapPinIn(pin));
	rsp_reset_strap_powerdown_ctrl #(.READY_HOLD_CYC(50), .REFRESH_CYC(8),
		.TICK_CYC(10)) rsp_reset_strap_powerdown_ctrl_i (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .resetInN(rstN), .testModeInput(tst),
		.strapPinIn(pin), .ctrlIn(ctrl), .coreReady(core), .outBus(ob),
		.hostLinkReady(rdy), .hostLinkReadyValid(vld),
		.environmentStrap(strap), .inReset(inRst), .timeOfDay(tod));
	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic t_strap(input logic d, input logic v);
		drv = d;
		val = v;
		rsp_host_model_i.hold_reset(6);
		`CHK(vld, 1'h0)
		`CHK(rdy, 1'h0)
		`CHK(inRst, 1'h1)
		for (int i = 0; i < 200 && vld !== 1'h1; i++) begin
			@(negedge clk_sys);
		end
		`CHK(vld, 1'h1)
		if (vld !== 1'h1) begin
			tally_and_finish();
		end
		drv = 1'h0;
		`CHK(rdy, 1'h1)
		`CHK(inRst, 1'h0)
		`CHK(strap, d ? v : 1'h1)
		`CHK(ob.expansionMemSelectOe, 1'h1)
		`CHK(ob.modulesOn, 1'h1)
		`CHK(ob.clockSlowEnable, 1'h1)
		core = 1'h0;
		ctrl.extMemAccess = 1'h1;
		@(negedge clk_sys);
		`CHK(ob.expansionMemSelectN, 1'h0)
		`CHK(rdy, 1'h0)
		core = 1'h1;
		ctrl.extMemAccess = 1'h0;
		`CHK(strap, d ? v : 1'h1)
	endtask
	task automatic t_sel();
		for (int i = 0; i < 4; i++) begin
			ctrl.selValid = 1'h1;
			ctrl.selIndex = i[1:0];
			@(negedge clk_sys);
			`CHK(ob.portBDeviceSelectLines, ~(4'h1 << i))
		end
		ctrl.selValid = 1'h0;
	endtask
	task automatic t_pd();
		logic seen;
		logic ticked;
		logic [4:0] slowN;
		logic [31:0] t0;
		seen = 1'h0;
		ticked = 1'h0;
		slowN = 5'h0;
		ctrl.powerDown = 1'h1;
		// The state changes on the first edge, the outputs on the second.
		repeat (2) @(negedge clk_sys);
		t0 = tod;
		`CHK(ob.portBDeviceSelectLines, 4'hf)
		`CHK(ob.modulesOn, 1'h0)
		for (int i = 0; i < 30; i++) begin
			@(negedge clk_sys);
			seen |= ob.refreshStrobe;
			ticked |= ob.timeTick;
			if (i < 16) begin
				slowN += ob.clockSlowEnable;
			end
		end
		`CHK(seen, 1'h1)
		`CHK(ticked, 1'h1)
		`CHK(slowN, 5'h1)
		`CHK(tod, t0 + 32'h3)
		ctrl.powerDown = 1'h0;
		repeat (2) @(negedge clk_sys);
		`CHK(ob.modulesOn, 1'h1)
		`CHK(ob.clockSlowEnable, 1'h1)
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'h0;
		t_strap(1'h1, 1'h0);
		t_sel();
		t_pd();
		t_strap(1'h0, 1'h0);
		tally_and_finish();
	end
endmodule
